//--- hdl/programmable_io_unit.sv
// Programmable 24-line parallel I/O unit with an APB register slave
`timescale 1ns/1ps

module programmable_io_unit (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [31:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire pio_pkg::pins_t pins_in,
  output pio_pkg::pins_t    pins_out,
  output pio_pkg::pins_t    pins_oe
);

  pio_pkg::config_t cfg;
  logic [7:0]       first_out;
  logic [7:0]       second_out;
  logic [7:0]       third_out;
  logic [7:0]       first_latch;
  pio_pkg::pins_t   sync1;
  pio_pkg::pins_t   sync2;
  pio_pkg::pins_t   sync3;
  pio_pkg::pins_t   pins_now;
  logic             obf;
  logic             ibf;
  logic             ack_seen;
  logic             strobe_seen;
  logic [1:0]       reg_sel;
  logic             wr_en;
  logic             rd_en;
  logic             ctl_wr;
  logic             data_wr;
  logic [7:0]       wbyte;
  logic [7:0]       next_rdata;
  logic             handshake;
  logic             bidir;
  logic [2:0]       bsr_sel;

  assign reg_sel   = paddr[pio_pkg::addr_word_lsb +: 2];
  assign wr_en     = psel && penable && pwrite;
  assign rd_en     = psel && penable && !pwrite;
  assign wbyte     = pwdata[7:0];
  assign ctl_wr    = wr_en && (reg_sel == pio_pkg::port_configuration_control_off);
  assign data_wr   = wr_en && (reg_sel != pio_pkg::port_configuration_control_off);
  assign handshake = cfg.mode != pio_pkg::mode_basic;
  assign bidir     = cfg.mode[1];
  assign bsr_sel   = wbyte[pio_pkg::ctl_bsr_sel_lsb +: 3];
  // Single-cycle slave; unmapped high address bits alias, no error case exists
  assign pready    = 1'b1;
  assign pslverr   = 1'b0;

  // Three stages; only the agreeing later two count, so the first stays private
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1    <= '0;
      sync2    <= '0;
      sync3    <= '0;
      pins_now <= '0;
    end else begin
      sync1 <= pins_in;
      sync2 <= sync1;
      sync3 <= sync2;
      for (int i = 0; i < 24; i++) begin
        if (sync2[i] == sync3[i]) begin
          pins_now[i] <= sync3[i];
        end
      end
    end
  end

  // Configuration register, all inputs after reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg <= pio_pkg::config_t'(pio_pkg::ctl_reset_value);
    end else if (ctl_wr && wbyte[pio_pkg::ctl_define_bit]) begin
      cfg.define       <= 1'b1;
      cfg.mode         <= wbyte[pio_pkg::ctl_mode_hi_bit] ? pio_pkg::mode_bidir
                        : pio_pkg::mode_t'(wbyte[pio_pkg::ctl_mode_hi_bit:pio_pkg::ctl_mode_lo_bit]);
      cfg.first_in     <= wbyte[pio_pkg::ctl_first_dir_bit];
      cfg.high_in      <= wbyte[pio_pkg::ctl_high_dir_bit];
      cfg.group_b_mode <= wbyte[pio_pkg::ctl_group_b_bit];
      cfg.second_in    <= wbyte[pio_pkg::ctl_second_dir_bit];
      cfg.low_in       <= wbyte[pio_pkg::ctl_low_dir_bit];
    end
  end

  // First and second port output latches
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      first_out  <= pio_pkg::out_reset_value;
      second_out <= pio_pkg::out_reset_value;
    end else if (ctl_wr && wbyte[pio_pkg::ctl_define_bit]) begin
      first_out  <= pio_pkg::out_reset_value;
      second_out <= pio_pkg::out_reset_value;
    end else if (data_wr && reg_sel == pio_pkg::first_port_data_off) begin
      first_out <= wbyte;
    end else if (data_wr && reg_sel == pio_pkg::second_port_data_off) begin
      second_out <= wbyte;
    end
  end

  // Third port latch; bit set/reset touches one line only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      third_out <= pio_pkg::out_reset_value;
    end else if (ctl_wr && wbyte[pio_pkg::ctl_define_bit]) begin
      third_out <= pio_pkg::out_reset_value;
    end else if (ctl_wr) begin
      third_out[bsr_sel] <= wbyte[pio_pkg::ctl_bsr_val_bit];
    end else if (data_wr && reg_sel == pio_pkg::third_port_data_off) begin
      third_out <= wbyte;
    end
  end

  // Handshake flags; the setting write or strobe edge wins over the clearing ack or read
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      obf         <= 1'b0;
      ibf         <= 1'b0;
      ack_seen    <= 1'b0;
      strobe_seen <= 1'b0;
    end else begin
      ack_seen    <= !pins_now.third[pio_pkg::hs_ack_n_bit];
      strobe_seen <= !pins_now.third[pio_pkg::hs_strobe_n_bit];
      // Of the control writes only a mode definition empties the buffer; line set/reset leaves it alone
      if (!handshake || (ctl_wr && wbyte[pio_pkg::ctl_define_bit])) begin
        obf <= 1'b0;
      end else if (data_wr && reg_sel == pio_pkg::first_port_data_off) begin
        obf <= 1'b1;
      end else if (ack_seen) begin
        obf <= 1'b0;
      end
      if (!handshake || (ctl_wr && wbyte[pio_pkg::ctl_define_bit])) begin
        ibf <= 1'b0;
      end else if (!strobe_seen && !pins_now.third[pio_pkg::hs_strobe_n_bit]) begin
        ibf <= 1'b1;
      end else if (rd_en && reg_sel == pio_pkg::first_port_data_off) begin
        ibf <= 1'b0;
      end
    end
  end

  // First port input latch: strobe edge in handshake modes, else follows pins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      first_latch <= 8'h00;
    end else if (!handshake) begin
      first_latch <= pins_now.first;
    end else if (!strobe_seen && !pins_now.third[pio_pkg::hs_strobe_n_bit]) begin
      first_latch <= pins_now.first;
    end
  end

  // Pin drivers; direction bit one means input
  always_comb begin
    pins_out.first  = first_out;
    pins_out.second = second_out;
    pins_out.third  = third_out;
    pins_oe.first   = {8{!cfg.first_in}};
    pins_oe.second  = {8{!cfg.second_in}};
    pins_oe.third   = {{4{!cfg.high_in}}, {4{!cfg.low_in}}};
    if (bidir) begin
      // Bus driven only while output is full and acknowledged
      pins_oe.first = {8{obf && ack_seen}};
    end
    if (handshake) begin
      pins_out.third[pio_pkg::hs_obf_n_bit] = !obf;
      pins_out.third[pio_pkg::hs_ibf_bit]   = ibf;
      pins_out.third[pio_pkg::hs_intr_bit]  = ibf || (obf == 1'b0);
      pins_oe.third[pio_pkg::hs_obf_n_bit]  = 1'b1;
      pins_oe.third[pio_pkg::hs_ibf_bit]    = 1'b1;
      pins_oe.third[pio_pkg::hs_intr_bit]   = 1'b1;
      pins_oe.third[pio_pkg::hs_strobe_n_bit] = 1'b0;
      pins_oe.third[pio_pkg::hs_ack_n_bit]  = 1'b0;
    end
  end

  // Read mux; first port output reads return its latch, the other ports return the pins
  always_comb begin
    next_rdata = 8'h00;
    case (reg_sel)
      pio_pkg::first_port_data_off:  next_rdata = cfg.first_in || bidir ? first_latch : first_out;
      pio_pkg::second_port_data_off: next_rdata = pins_now.second;
      pio_pkg::third_port_data_off:  next_rdata = pins_now.third;
      default:                       next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h00_0000, next_rdata};
    end
  end

  reset_all_in_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(resetn) |-> pins_oe == '0)
    else $error("ports not all inputs after reset");
  ctl_clears_a: assert property (@(posedge clk) disable iff (!resetn)
    ctl_wr && wbyte[7] |=> first_out == 8'h00 && second_out == 8'h00 && third_out == 8'h00)
    else $error("control write did not clear outputs");
  all_out_a: assert property (@(posedge clk) disable iff (!resetn)
    ctl_wr && wbyte == 8'h80 |=> pins_oe == {24{1'b1}})
    else $error("80h did not make all outputs");
  all_in_a: assert property (@(posedge clk) disable iff (!resetn)
    ctl_wr && wbyte == 8'h9B |=> pins_oe == '0)
    else $error("9Bh did not make all inputs");
  bsr_keeps_cfg_a: assert property (@(posedge clk) disable iff (!resetn)
    ctl_wr && !wbyte[7] |=> $stable(cfg) && third_out[$past(bsr_sel)] == $past(wbyte[0]))
    else $error("bit set/reset misapplied");
  first_write_a: assert property (@(posedge clk) disable iff (!resetn)
    data_wr && reg_sel == 2'h0 |=> first_out == $past(wbyte))
    else $error("first port latch not written");
  nibble_dir_a: assert property (@(posedge clk) disable iff (!resetn)
    ctl_wr && wbyte == 8'h88 |=> pins_oe.third == 8'h0F)
    else $error("nibble directions wrong");
  mode_sel_a: assert property (@(posedge clk) disable iff (!resetn)
    ctl_wr && wbyte[7:5] == 3'b101 |=> cfg.mode == pio_pkg::mode_strobed)
    else $error("strobed mode not selected");


  ctl_read_zero_a: assert property (@(posedge clk) disable iff (!resetn)
    psel && !penable && !pwrite && reg_sel == pio_pkg::port_configuration_control_off
      |=> prdata == 32'h0000_0000)
    else $error("control word read not zero");

  second_write_a: assert property (@(posedge clk) disable iff (!resetn)
    data_wr && reg_sel == pio_pkg::second_port_data_off
      |=> second_out == $past(wbyte))
    else $error("second port latch not written");

  third_write_a: assert property (@(posedge clk) disable iff (!resetn)
    data_wr && reg_sel == pio_pkg::third_port_data_off
      |=> third_out == $past(wbyte))
    else $error("third port latch not written");

  lines_follow_a: assert property (@(posedge clk) disable iff (!resetn)
    !handshake
      |-> pins_out == {first_out, second_out, third_out})
    else $error("basic mode lines differ from latches");

  high_dir_a: assert property (@(posedge clk) disable iff (!resetn)
    !handshake
      |-> pins_oe.third[7:4] == {4{!cfg.high_in}})
    else $error("high nibble direction wrong");

  group_b_kept_a: assert property (@(posedge clk) disable iff (!resetn)
    ctl_wr && wbyte[pio_pkg::ctl_define_bit]
      |=> cfg.group_b_mode == $past(wbyte[pio_pkg::ctl_group_b_bit]))
    else $error("bit 2 setting not stored");

  obf_set_a: assert property (@(posedge clk) disable iff (!resetn)
    handshake && data_wr && reg_sel == pio_pkg::first_port_data_off
      |=> obf)
    else $error("output buffer flag not set");

  ibf_set_a: assert property (@(posedge clk) disable iff (!resetn)
    handshake && !strobe_seen && !pins_now.third[pio_pkg::hs_strobe_n_bit]
      && !(ctl_wr && wbyte[pio_pkg::ctl_define_bit])
      |=> ibf)
    else $error("input buffer flag not set");

  // Main scenarios worth seeing at least once
  cfg_write_c: cover property (@(posedge clk) disable iff (!resetn) ctl_wr && wbyte[7]);
  strobe_capture_c: cover property (@(posedge clk) disable iff (!resetn)
    handshake && ibf);
  bidir_drive_c: cover property (@(posedge clk) disable iff (!resetn)
    bidir && obf && ack_seen);
  bsr_write_c: cover property (@(posedge clk) disable iff (!resetn) ctl_wr && !wbyte[7]);
  read_back_c: cover property (@(posedge clk) disable iff (!resetn) rd_en && reg_sel == 2'h1);

endmodule

//--- hdl/pio_pkg.sv
// Package: register map, control word fields and shared types of the parallel I/O unit
package pio_pkg;
  localparam logic [1:0] first_port_data_off            = 2'h0;
  localparam logic [1:0] second_port_data_off           = 2'h1;
  localparam logic [1:0] third_port_data_off            = 2'h2;
  localparam logic [1:0] port_configuration_control_off = 2'h3;
  localparam int         addr_word_lsb                  = 2;
  localparam int         port_width                     = 8;
  // Control word fields
  localparam int ctl_define_bit    = 7;
  localparam int ctl_mode_hi_bit   = 6;
  localparam int ctl_mode_lo_bit   = 5;
  localparam int ctl_first_dir_bit = 4;
  localparam int ctl_high_dir_bit  = 3;
  localparam int ctl_group_b_bit   = 2;
  localparam int ctl_second_dir_bit = 1;
  localparam int ctl_low_dir_bit   = 0;
  localparam int ctl_bsr_sel_lsb   = 1;
  localparam int ctl_bsr_val_bit   = 0;
  localparam logic [7:0] ctl_reset_value = 8'h9B;
  localparam logic [7:0] out_reset_value = 8'h00;
  // Strobed mode handshake lines on the third port
  localparam int hs_strobe_n_bit = 4;
  localparam int hs_ibf_bit      = 5;
  localparam int hs_ack_n_bit    = 6;
  localparam int hs_obf_n_bit    = 7;
  localparam int hs_intr_bit     = 3;

  typedef enum logic [1:0] {
    mode_basic   = 2'b00,
    mode_strobed = 2'b01,
    mode_bidir   = 2'b11
  } mode_t;

  typedef struct packed {
    logic       define;
    mode_t      mode;
    logic       first_in;
    logic       high_in;
    logic       group_b_mode;
    logic       second_in;
    logic       low_in;
  } config_t;

  typedef struct packed {
    logic [7:0] first;
    logic [7:0] second;
    logic [7:0] third;
  } pins_t;
endpackage

//--- verif/field_wiring.sv
// Field wiring model: driven lines loop back, released lines show the field
`timescale 1ns/1ps
module field_wiring (
  input  wire pio_pkg::pins_t pins_out,
  input  wire pio_pkg::pins_t pins_oe,
  input  wire pio_pkg::pins_t field,
  output pio_pkg::pins_t      pins_in
);
  // Released lines never keep the last driven level
  assign pins_in = (pins_out & pins_oe) | (field & ~pins_oe);
endmodule

//--- verif/programmable_parallel_io_port_bench.sv
// Bench for the parallel I/O unit over APB
`timescale 1ns/1ps
module programmable_parallel_io_port_bench;
  logic           clk;
  logic           resetn;
  logic           psel;
  logic           penable;
  logic           pwrite;
  logic [31:0]    paddr;
  logic [31:0]    pwdata;
  logic [31:0]    prdata;
  logic [31:0]    rd;
  logic           pready;
  logic           pslverr;
  pio_pkg::pins_t pins_in;
  pio_pkg::pins_t pins_out;
  pio_pkg::pins_t pins_oe;
  pio_pkg::pins_t field;
  int             errors;
  int             n_compared;
  localparam logic [31:0] ctl = 32'h0000000C;

  programmable_io_unit dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins_in(pins_in), .pins_out(pins_out), .pins_oe(pins_oe));
  field_wiring wiring (.pins_out(pins_out), .pins_oe(pins_oe), .field(field),
    .pins_in(pins_in));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 100) begin
      errors++;
      tally_and_finish();
    end
    #1;
  endtask

  // Read one port and compare its byte word
  task automatic rchk(input string name, input logic [31:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    chk(name, rd, {24'h000000, exp});
    chk("pready", {31'h0, pready}, 32'h1);
    chk("pslverr", {31'h0, pslverr}, 32'h0);
  endtask

  function automatic logic [23:0] oe_of(input logic [7:0] c);
    oe_of = {{8{~c[4]}}, {8{~c[1]}}, {4{~c[3]}}, {4{~c[0]}}};
  endfunction

  task automatic t_reset;
    chk("oe", pins_oe, 32'h0);
    field <= 24'hA55A3C;
    repeat (6) @(posedge clk);
    rchk("first", 32'h0, 8'hA5);
    rchk("second", 32'h4, 8'h5A);
    rchk("third", 32'h8, 8'h3C);
    rchk("control", ctl, 8'h00);
    rchk("alias", 32'h10, 8'hA5);
  endtask

  task automatic t_table;
    logic [7:0] c;
    for (int i = 0; i < 16; i++) begin
      // Bit 2 stays clear for basic mode
      c = {3'b100, i[3], i[2], 1'b0, i[1], i[0]};
      xfer(1'b1, ctl, c);
      chk("oe", pins_oe, oe_of(c));
    end
  endtask

  task automatic t_data;
    xfer(1'b1, ctl, 8'h80);
    xfer(1'b1, 32'h0, 8'h22);
    xfer(1'b1, 32'h4, 8'h63);
    xfer(1'b1, 32'h8, 8'h5A);
    chk("pins", pins_out, 32'h22635A);
    field <= 24'hDD9CA5;
    repeat (6) @(posedge clk);
    rchk("first", 32'h0, 8'h22);
    rchk("second", 32'h4, 8'h63);
    xfer(1'b1, ctl, 8'h80);
    chk("cleared", pins_out, 32'h0);
    xfer(1'b1, 32'h0, 8'h11);
    xfer(1'b1, ctl, 8'h07);
    chk("set", pins_out, 32'h110008);
    xfer(1'b1, ctl, 8'h06);
    chk("reset", pins_out, 32'h110000);
    chk("oe", pins_oe, 32'hFFFFFF);
  endtask

  task automatic t_mode;
    xfer(1'b1, ctl, 8'hA0);
    chk("first oe", pins_oe.first, 32'hFF);
    chk("hs oe", pins_oe.third[7:6], 32'h2);
    xfer(1'b1, ctl, 8'h9B);
    chk("oe", pins_oe, 32'h0);
  endtask

  initial begin
    errors = 0;
    n_compared = 0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    field = 24'h000000;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_table();
    t_data();
    t_mode();
    tally_and_finish();
  end
endmodule
